// ### rtl/cpap_defs.vh
`ifndef CPAP_DEFS_VH
`define CPAP_DEFS_VH

// Access kinds on the request port
`define CPAP_KIND_LOAD   2'h0
`define CPAP_KIND_STORE  2'h1
`define CPAP_KIND_IFETCH 2'h2

// Pending action codes
`define CPAP_ACT_NONE   2'h0
`define CPAP_ACT_GATHER 2'h1
`define CPAP_ACT_MEM    2'h2

// Idle cycles a gathered store may wait before draining
`define CPAP_GATHER_HOLD 4'h8

`endif

// ### rtl/cpap_policy.v
// Summary of operation
// R01: Write-through store goes to memory and updates the cache when resident.
// R02: Write-through store never makes a cache block modified.
// R03: Write-through hit on a modified block keeps the modified mark.
// R04: Write-through stores may gather, never across a barrier.
// R05: Caching-inhibited load goes to memory and never allocates a cache copy.
// R06: Caching-inhibited load reads extra locations only when not guarded.
// R07: Caching-inhibited fetch may read extra words but never fills a cache.
// R08: Caching-inhibited store always reaches memory; cache update is a parameter.
// R09: Caching-inhibited load hitting the cache may use it, by parameter.
// R10: Non-overlapping inhibited accesses gather, never across barrier or when guarded.
// R11: Stores to one coherent location are serialized, one access at a time.
// R12: Accesses complete in order so no older value follows a newer one.
// R13: Coherence is tracked per block of BLOCK_BYTES bytes.
// R14: Coherence-not-required pages issue non-coherent accesses.
// R15: Write-back pages may still be written through the first level.
// R16: Store-shadow mode writes cacheable write-back stores through to the second level.
// R17: Mixed write-back and write-through aliases stay private to one processor.
// R18: Write-through with caching-inhibited is refused with an error.
// R19: Guarded memory refuses speculative loads that would reach memory.
// R20: Attributes are latched with the request and held until completion.
`include "cpap_defs.vh"

module cpap_policy #(
  parameter AW                 = 32,
  parameter DW                 = 64,
  parameter BW                 = 3,
  parameter BLOCK_BYTES        = 32,
  parameter GATHER_EN          = 1,
  parameter STORE_SHADOW       = 0,
  parameter CI_LOAD_USE_CACHE  = 0,
  parameter CI_STORE_UPD_CACHE = 0
) (
  // Clock and reset
  input  wire            clk_in,
  input  wire            reset_n_in,
  // Core request
  input  wire            req_valid_in,
  input  wire [1:0]      req_kind_in,
  input  wire [AW-1:0]   req_addr_in,
  input  wire [DW-1:0]   req_wdata_in,
  input  wire [DW/8-1:0] req_be_in,
  input  wire            req_w_in,
  input  wire            req_i_in,
  input  wire            req_m_in,
  input  wire            req_g_in,
  input  wire            req_spec_in,
  input  wire            barrier_in,
  output wire            req_ready_out,
  // Cache lookup result for the offered request
  input  wire            cache_hit_in,
  input  wire            cache_mod_in,
  input  wire [DW-1:0]   cache_rdata_in,
  // Core response
  output wire            resp_valid_out,
  output wire [DW-1:0]   resp_data_out,
  output wire            resp_err_out,
  output wire            resp_retry_out,
  // Data cache write
  output wire            cache_wr_out,
  output wire [AW-1:0]   cache_addr_out,
  output wire [DW-1:0]   cache_wdata_out,
  output wire [DW/8-1:0] cache_be_out,
  output wire            cache_set_mod_out,
  output wire            cache_keep_mod_out,
  // Next level and memory
  output wire            mem_valid_out,
  output wire            mem_we_out,
  output wire [AW-1:0]   mem_addr_out,
  output wire [DW-1:0]   mem_wdata_out,
  output wire [DW/8-1:0] mem_be_out,
  output wire            mem_wide_out,
  output wire            mem_alloc_out,
  output wire            mem_coh_out,
  output wire            mem_l2_out,
  input  wire            mem_ready_in,
  input  wire            mem_rvalid_in,
  input  wire [DW-1:0]   mem_rdata_in
);

  localparam S_IDLE  = 2'h0;
  localparam S_FLUSH = 2'h1;
  localparam S_MEM   = 2'h2;
  localparam S_RD    = 2'h3;
  localparam [3:0] HOLD = `CPAP_GATHER_HOLD;
  localparam NB = DW / 8;
  localparam BLK_LG = $clog2(BLOCK_BYTES);

  reg  [1:0]    state_r;
  reg           ready_r;
  reg           resp_v_r;
  reg  [DW-1:0] resp_d_r;
  reg           resp_e_r;
  reg           resp_t_r;
  reg           c_wr_r;
  reg  [AW-1:0] c_addr_r;
  reg  [DW-1:0] c_data_r;
  reg  [NB-1:0] c_be_r;
  reg           c_set_r;
  reg           c_keep_r;
  reg           m_v_r;
  reg           m_we_r;
  reg  [AW-1:0] m_addr_r;
  reg  [DW-1:0] m_data_r;
  reg  [NB-1:0] m_be_r;
  reg           m_wide_r;
  reg           m_alloc_r;
  reg           m_coh_r;
  reg           m_l2_r;
  // Latched request
  reg  [1:0]    cur_act_r;
  reg  [1:0]    cur_kind_r;
  reg  [AW-1:0] cur_addr_r;
  reg  [DW-1:0] cur_data_r;
  reg  [NB-1:0] cur_be_r;
  reg           cur_w_r;
  reg           cur_i_r;
  reg           cur_m_r;
  reg           cur_g_r;
  reg           cur_l2_r;
  // Gather buffer
  reg           gat_v_r;
  reg  [AW-1:0] gat_addr_r;
  reg  [DW-1:0] gat_data_r;
  reg  [NB-1:0] gat_be_r;
  reg           gat_w_r;
  reg           gat_i_r;
  reg           gat_m_r;
  reg  [3:0]    gat_hold_r;
  reg           bar_pend_r;

  wire          accept = req_valid_in & ready_r & (state_r == S_IDLE);
  wire          is_ld  = req_kind_in == `CPAP_KIND_LOAD;
  wire          is_st  = req_kind_in == `CPAP_KIND_STORE;
  wire          is_if  = req_kind_in == `CPAP_KIND_IFETCH;
  wire          illegal = req_w_in & req_i_in;
  wire          hit_ok = ~is_st & cache_hit_in & (~req_i_in | (is_ld & (CI_LOAD_USE_CACHE != 0)));
  wire          spec_blk = req_spec_in & req_g_in & ~hit_ok & ~is_if;
  wire          gatherable = is_st & (GATHER_EN != 0) & (req_w_in | (req_i_in & ~req_g_in));
  wire          same_dw = gat_addr_r[AW-1:BW] == req_addr_in[AW-1:BW];
  wire          same_att = (gat_w_r == req_w_in) & (gat_i_r == req_i_in) & (gat_m_r == req_m_in);
  // Gathered bytes never span two coherence blocks
  wire          same_blk = gat_addr_r[AW-1:BLK_LG] == req_addr_in[AW-1:BLK_LG];  // R13
  wire          no_ovl = ~req_i_in | ((gat_be_r & req_be_in) == {NB{1'b0}});
  wire          bar_any = bar_pend_r | barrier_in;
  wire          merge_ok = gat_v_r & gatherable & same_dw & same_blk & same_att & no_ovl & ~bar_any;
  wire          wb_hit = is_st & ~req_w_in & ~req_i_in & cache_hit_in & (STORE_SHADOW == 0);
  wire          c_upd = is_st & cache_hit_in & ~illegal & ~spec_blk
                        & (~req_i_in | (CI_STORE_UPD_CACHE != 0));
  wire          to_mem = ~illegal & ~spec_blk & ~hit_ok & ~merge_ok & ~gatherable & ~wb_hit;
  wire [DW-1:0] mrg_data;
  wire          flush_go = gat_v_r & ~req_valid_in & (bar_any | gat_hold_r == 4'h0);

  // Byte merge into the gather buffer
  genvar gi;
  generate
    for (gi = 0; gi < NB; gi = gi + 1) begin : g_mrg
      assign mrg_data[gi*8+7:gi*8] = req_be_in[gi] ? req_wdata_in[gi*8+7:gi*8] : gat_data_r[gi*8+7:gi*8];
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // Policy engine
  // ---------------------------------------------------------------------------
  always @(posedge clk_in) begin
    if (!reset_n_in) begin
      state_r    <= S_IDLE;
      ready_r    <= 1'b0;
      resp_v_r   <= 1'b0;
      resp_d_r   <= {DW{1'b0}};
      resp_e_r   <= 1'b0;
      resp_t_r   <= 1'b0;
      c_wr_r     <= 1'b0;
      c_addr_r   <= {AW{1'b0}};
      c_data_r   <= {DW{1'b0}};
      c_be_r     <= {NB{1'b0}};
      c_set_r    <= 1'b0;
      c_keep_r   <= 1'b0;
      m_v_r      <= 1'b0;
      m_we_r     <= 1'b0;
      m_addr_r   <= {AW{1'b0}};
      m_data_r   <= {DW{1'b0}};
      m_be_r     <= {NB{1'b0}};
      m_wide_r   <= 1'b0;
      m_alloc_r  <= 1'b0;
      m_coh_r    <= 1'b0;
      m_l2_r     <= 1'b0;
      cur_act_r  <= `CPAP_ACT_NONE;
      cur_kind_r <= `CPAP_KIND_LOAD;
      cur_addr_r <= {AW{1'b0}};
      cur_data_r <= {DW{1'b0}};
      cur_be_r   <= {NB{1'b0}};
      cur_w_r    <= 1'b0;
      cur_i_r    <= 1'b0;
      cur_m_r    <= 1'b0;
      cur_g_r    <= 1'b0;
      cur_l2_r   <= 1'b0;
      gat_v_r    <= 1'b0;
      gat_addr_r <= {AW{1'b0}};
      gat_data_r <= {DW{1'b0}};
      gat_be_r   <= {NB{1'b0}};
      gat_w_r    <= 1'b0;
      gat_i_r    <= 1'b0;
      gat_m_r    <= 1'b0;
      gat_hold_r <= HOLD;
      bar_pend_r <= 1'b0;
    end else begin
      resp_v_r <= 1'b0;
      resp_e_r <= 1'b0;
      resp_t_r <= 1'b0;
      c_wr_r   <= 1'b0;
      // Barrier seen while busy stays pending; set wins over clear
      if (barrier_in)
        bar_pend_r <= 1'b1;
      else if (state_r == S_IDLE && !gat_v_r)
        bar_pend_r <= 1'b0;
      if (gat_v_r && state_r == S_IDLE && gat_hold_r != 4'h0)
        gat_hold_r <= gat_hold_r - 4'h1;
      case (state_r)
        S_IDLE: begin
          ready_r <= 1'b1;
          if (accept) begin
            // Attributes held with the request until completion
            cur_kind_r <= req_kind_in;                                   // R20
            cur_addr_r <= req_addr_in;
            cur_data_r <= req_wdata_in;
            cur_be_r   <= req_be_in;
            cur_w_r    <= req_w_in;
            cur_i_r    <= req_i_in;
            cur_m_r    <= req_m_in;
            cur_g_r    <= req_g_in;
            cur_l2_r   <= is_st & ~req_w_in & ~req_i_in & (STORE_SHADOW != 0);  // R15 R16
            c_wr_r     <= c_upd;                                         // R01 R08
            c_addr_r   <= req_addr_in;
            c_data_r   <= req_wdata_in;
            c_be_r     <= req_be_in;
            c_set_r    <= wb_hit;                                        // R02 R16
            c_keep_r   <= cache_mod_in & req_w_in;                       // R03
            if (illegal) begin
              resp_v_r <= 1'b1;                                          // R18
              resp_e_r <= 1'b1;
            end else if (spec_blk) begin
              resp_v_r <= 1'b1;                                          // R19
              resp_t_r <= 1'b1;
            end else if (hit_ok) begin
              resp_v_r <= 1'b1;                                          // R09
              resp_d_r <= cache_rdata_in;
            end else if (merge_ok) begin
              gat_data_r <= mrg_data;                                    // R04 R10
              gat_be_r   <= gat_be_r | req_be_in;
              gat_hold_r <= HOLD;
              resp_v_r   <= 1'b1;
            end else if (wb_hit) begin
              resp_v_r <= 1'b1;
            end else if (gatherable && !gat_v_r) begin
              gat_v_r    <= 1'b1;
              gat_addr_r <= req_addr_in;
              gat_data_r <= req_wdata_in;
              gat_be_r   <= req_be_in;
              gat_w_r    <= req_w_in;
              gat_i_r    <= req_i_in;
              gat_m_r    <= req_m_in;
              gat_hold_r <= HOLD;
              resp_v_r   <= 1'b1;
            end else begin
              // Drain older gathered stores first to keep order
              cur_act_r <= to_mem ? `CPAP_ACT_MEM : `CPAP_ACT_GATHER;  // R12
              ready_r   <= 1'b0;
              m_v_r     <= 1'b1;
              if (gat_v_r) begin
                state_r   <= S_FLUSH;
                m_we_r    <= 1'b1;
                m_addr_r  <= gat_addr_r;
                m_data_r  <= gat_data_r;
                m_be_r    <= gat_be_r;
                m_wide_r  <= 1'b0;
                m_alloc_r <= 1'b0;
                m_coh_r   <= gat_m_r;
                m_l2_r    <= 1'b0;
              end else begin
                state_r   <= S_MEM;
                m_we_r    <= is_st;                                      // R01 R08
                m_addr_r  <= req_addr_in;
                m_data_r  <= req_wdata_in;
                m_be_r    <= req_be_in;
                m_wide_r  <= ~is_st & (~req_i_in | ~req_g_in | is_if);  // R06 R07
                m_alloc_r <= ~req_i_in & ~req_w_in;                      // R05 R07
                m_coh_r   <= req_m_in;                                   // R14
                m_l2_r    <= is_st & ~req_w_in & ~req_i_in & (STORE_SHADOW != 0);
              end
            end
          end else if (flush_go) begin
            cur_act_r <= `CPAP_ACT_NONE;
            state_r   <= S_FLUSH;
            ready_r   <= 1'b0;
            m_v_r     <= 1'b1;
            m_we_r    <= 1'b1;
            m_addr_r  <= gat_addr_r;
            m_data_r  <= gat_data_r;
            m_be_r    <= gat_be_r;
            m_wide_r  <= 1'b0;
            m_alloc_r <= 1'b0;
            m_coh_r   <= gat_m_r;
            m_l2_r    <= 1'b0;
          end
        end
        S_FLUSH: begin
          if (mem_ready_in) begin
            gat_v_r <= 1'b0;
            m_v_r   <= 1'b0;
            if (!barrier_in)
              bar_pend_r <= 1'b0;                                        // R04 R10
            if (cur_act_r == `CPAP_ACT_GATHER) begin
              gat_v_r    <= 1'b1;
              gat_addr_r <= cur_addr_r;
              gat_data_r <= cur_data_r;
              gat_be_r   <= cur_be_r;
              gat_w_r    <= cur_w_r;
              gat_i_r    <= cur_i_r;
              gat_m_r    <= cur_m_r;
              gat_hold_r <= HOLD;
              resp_v_r   <= 1'b1;
              state_r    <= S_IDLE;
              ready_r    <= 1'b1;
            end else if (cur_act_r == `CPAP_ACT_MEM) begin
              state_r   <= S_MEM;
              m_v_r     <= 1'b1;
              m_we_r    <= cur_kind_r == `CPAP_KIND_STORE;
              m_addr_r  <= cur_addr_r;
              m_data_r  <= cur_data_r;
              m_be_r    <= cur_be_r;
              m_wide_r  <= cur_kind_r != `CPAP_KIND_STORE
                           & (~cur_i_r | ~cur_g_r | cur_kind_r == `CPAP_KIND_IFETCH);  // R06 R07
              m_alloc_r <= ~cur_i_r & ~cur_w_r;                          // R05
              m_coh_r   <= cur_m_r;                                      // R14
              m_l2_r    <= cur_l2_r;                                     // R16
            end else begin
              state_r <= S_IDLE;
              ready_r <= 1'b1;
            end
          end
        end
        S_MEM: begin
          // One access outstanding serializes coherent stores
          if (mem_ready_in) begin                                        // R11
            m_v_r <= 1'b0;
            if (m_we_r) begin
              resp_v_r <= 1'b1;
              state_r  <= S_IDLE;
              ready_r  <= 1'b1;
            end else begin
              state_r <= S_RD;
            end
          end
        end
        default: begin
          if (mem_rvalid_in) begin
            resp_v_r <= 1'b1;                                            // R12
            resp_d_r <= mem_rdata_in;
            state_r  <= S_IDLE;
            ready_r  <= 1'b1;
          end
        end
      endcase
    end
  end

  assign req_ready_out      = ready_r;
  assign resp_valid_out     = resp_v_r;
  assign resp_data_out      = resp_d_r;
  assign resp_err_out       = resp_e_r;
  assign resp_retry_out     = resp_t_r;
  assign cache_wr_out       = c_wr_r;
  assign cache_addr_out     = c_addr_r;
  assign cache_wdata_out    = c_data_r;
  assign cache_be_out       = c_be_r;
  assign cache_set_mod_out  = c_set_r;
  assign cache_keep_mod_out = c_keep_r;
  assign mem_valid_out      = m_v_r;
  assign mem_we_out         = m_we_r;
  assign mem_addr_out       = m_addr_r;
  assign mem_wdata_out      = m_data_r;
  assign mem_be_out         = m_be_r;
  assign mem_wide_out       = m_wide_r;
  assign mem_alloc_out      = m_alloc_r;
  assign mem_coh_out        = m_coh_r;
  assign mem_l2_out         = m_l2_r;

endmodule // cpap_policy

// ### verification/cpap_mem_model.sv
module cpap_mem_model (
  // Clock, reset, pacing
  input  wire logic        clk_in,
  input  wire logic        reset_n_in,
  input  wire logic        slow_in,
  // Request from the block
  input  wire logic        mem_valid_in,
  input  wire logic        mem_we_in,
  input  wire logic [31:0] mem_addr_in,
  // Answers
  output logic             mem_ready_out,
  output logic             mem_rvalid_out,
  output logic [63:0]      mem_rdata_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0]  wait_r;
  logic        rd_r;
  logic [31:0] addr_r;

  // Serves a single requester, so aliased blocks stay private
  always @(posedge clk_in) begin
    mem_ready_out  <= 1'h0;
    mem_rvalid_out <= 1'h0;
    mem_rdata_out  <= ~mem_rdata_out;
    if (!reset_n_in) begin
      {wait_r, rd_r, mem_rdata_out} <= '0;
    end else if (rd_r) begin
      mem_rvalid_out <= 1'h1;
      mem_rdata_out  <= {addr_r, ~addr_r};
      rd_r           <= 1'h0;
    end else if (mem_valid_in && mem_ready_out) begin
      rd_r   <= !mem_we_in;
      addr_r <= mem_addr_in;
    end else if (mem_valid_in) begin
      wait_r <= wait_r + 2'h1;
      if (wait_r == (slow_in ? 2'h3 : 2'h0)) begin
        mem_ready_out <= 1'h1;
        wait_r        <= 2'h0;
      end
    end
  end
endmodule // cpap_mem_model

// ### verification/cpap_policy_asserts.sv
`include "cpap_defs.vh"

module cpap_policy_asserts #(
  parameter AW                 = 32,
  parameter STORE_SHADOW       = 0,
  parameter CI_STORE_UPD_CACHE = 0
) (
  // Clock and request
  input wire logic          clk_in,
  input wire logic          reset_n_in,
  input wire logic          req_valid_in,
  input wire logic          req_ready_out,
  input wire logic [1:0]    req_kind_in,
  input wire logic          req_w_in,
  input wire logic          req_i_in,
  input wire logic          req_m_in,
  input wire logic          req_g_in,
  input wire logic          req_spec_in,
  input wire logic          cache_hit_in,
  // Answers and cache
  input wire logic          resp_valid_out,
  input wire logic          resp_err_out,
  input wire logic          resp_retry_out,
  input wire logic          cache_wr_out,
  input wire logic          cache_set_mod_out,
  // Memory side
  input wire logic          mem_valid_out,
  input wire logic          mem_ready_in,
  input wire logic          mem_we_out,
  input wire logic [AW-1:0] mem_addr_out,
  input wire logic          mem_wide_out,
  input wire logic          mem_alloc_out,
  input wire logic          mem_coh_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // --------------------
  // Attributes of the access in flight
  // --------------------
  logic       pend_r;
  logic [3:0] at_r;
  wire        take = req_valid_in && req_ready_out;
  wire        rd   = pend_r && mem_valid_out && !mem_we_out;

  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  always @(posedge clk_in) begin
    if (!reset_n_in || resp_valid_out)
      pend_r <= 1'h0;
    if (take) begin
      pend_r <= 1'h1;
      at_r   <= {req_kind_in == `CPAP_KIND_LOAD, req_i_in, req_m_in, req_g_in};
    end
  end

  a_mem_req_held: assert property (mem_valid_out && !mem_ready_in |=>
    mem_valid_out && $stable(mem_addr_out) && $stable(mem_we_out)) else $error("memory request dropped early");
  a_wt_no_modify: assert property (take && req_kind_in == `CPAP_KIND_STORE && req_w_in && !req_i_in
    |=> !cache_set_mod_out) else $error("write-through store set modified");
  a_wi_refused: assert property (take && req_w_in && req_i_in |=>
    resp_valid_out && resp_err_out && !cache_wr_out) else $error("write-through inhibited not refused");
  a_guard_retry: assert property (take && req_kind_in == `CPAP_KIND_LOAD && req_spec_in && req_g_in &&
    !req_w_in && (req_i_in || !cache_hit_in) |=> resp_valid_out && resp_retry_out) else $error("no retry");
  a_ci_no_alloc: assert property (rd && at_r[2] |-> !mem_alloc_out)
    else $error("inhibited read may allocate");
  a_ci_guard_narrow: assert property (rd && at_r[3] && at_r[2] && at_r[0] |-> !mem_wide_out)
    else $error("guarded inhibited load reads extra");
  a_coh_follows: assert property (rd |-> mem_coh_out == at_r[1])
    else $error("coherence flag differs from page");
  a_ci_no_cache: assert property (pend_r && at_r[2] && CI_STORE_UPD_CACHE == 0 |-> !cache_wr_out)
    else $error("inhibited access wrote the cache");
  a_resp_bounded: assert property (take |-> ##[1:200] resp_valid_out)
    else $error("request never answered");
  a_shadow_clean: assert property (STORE_SHADOW != 0 && cache_wr_out |-> !cache_set_mod_out)
    else $error("store-shadow cache holds modified data");
endmodule // cpap_policy_asserts

bind cpap_policy cpap_policy_asserts #(.AW(AW), .STORE_SHADOW(STORE_SHADOW),
  .CI_STORE_UPD_CACHE(CI_STORE_UPD_CACHE)) u_chk (.*);

// ### verification/tb_top.sv
`include "cpap_defs.vh"
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin err_total++; $display("unexpected %0t: got %0h want %0h", $time, a, e); end end

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_in, reset_n_in = 1'h0, req_valid_in = 1'h0, req_w_in = 1'h0, req_i_in = 1'h0;
  logic        req_m_in = 1'h0, req_g_in = 1'h0, req_spec_in = 1'h0, barrier_in = 1'h0, cache_hit_in = 1'h0;
  logic        cache_mod_in = 1'h0, slow = 1'h0, r_err, r_retry;
  logic [1:0]  req_kind_in = 2'h0, c_fl;
  logic [31:0] req_addr_in = 32'h0, m_addr;
  logic [63:0] req_wdata_in = 64'h0, cache_rdata_in = 64'h0123456789abcdef, r_data, m_data;
  logic [7:0]  req_be_in = 8'h0;
  logic [11:0] m_fl;
  wire         req_ready_out, resp_valid_out, resp_err_out, resp_retry_out, cache_wr_out, mem_coh_out;
  wire         cache_set_mod_out, cache_keep_mod_out, mem_valid_out, mem_we_out, mem_wide_out;
  wire         mem_alloc_out, mem_l2_out, mem_ready_in, mem_rvalid_in;
  wire  [31:0] cache_addr_out, mem_addr_out;
  wire  [63:0] resp_data_out, cache_wdata_out, mem_wdata_out, mem_rdata_in;
  wire  [7:0]  cache_be_out, mem_be_out;
  int          err_total = 0, n_compared = 0, mem_n = 0, c_n = 0, n0, c0, k;

  cpap_policy u_dut (.*);
  cpap_mem_model u_mem (.clk_in(clk_in), .reset_n_in(reset_n_in), .slow_in(slow), .mem_valid_in(mem_valid_out),
    .mem_we_in(mem_we_out), .mem_addr_in(mem_addr_out), .mem_ready_out(mem_ready_in),
    .mem_rvalid_out(mem_rvalid_in), .mem_rdata_out(mem_rdata_in));

  initial begin
    clk_in = 1'h0;
    forever #2.5 clk_in = ~clk_in;
  end

  // Memory beats: we, wide, alloc, coh, be
  always @(posedge clk_in) begin
    if (mem_valid_out && mem_ready_in) begin
      mem_n  <= mem_n + 1;
      m_fl   <= {mem_we_out, mem_wide_out, mem_alloc_out, mem_coh_out, mem_be_out};
      {m_addr, m_data} <= {mem_addr_out, mem_wdata_out};
    end
    if (cache_wr_out) begin
      c_n  <= c_n + 1;
      c_fl <= {cache_set_mod_out, cache_keep_mod_out};
    end
  end
  // --------------------
  // Helpers
  // --------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  // Attributes at: w, i, m, g, spec; hm: hit, modified
  task automatic issue(input logic [1:0] kd, input logic [31:0] a, input logic [63:0] d,
                       input logic [7:0] b, input logic [4:0] at, input logic [1:0] hm);
    int n;
    {req_kind_in, req_addr_in, req_wdata_in, req_be_in} = {kd, a, d, b};
    {req_w_in, req_i_in, req_m_in, req_g_in, req_spec_in, cache_hit_in, cache_mod_in} = {at, hm};
    req_valid_in = 1'h1;
    for (n = 0; n < 50 && req_ready_out !== 1'h1; n++) cyc(1);
    cyc(1);
    req_valid_in = 1'h0;
    {req_w_in, req_i_in, req_m_in, req_g_in} = ~at[4:1];
    for (n = 0; n < 50 && resp_valid_out !== 1'h1; n++) cyc(1);
    `CHK(n < 50, 1'h1)
    {r_err, r_retry, r_data} = {resp_err_out, resp_retry_out, resp_data_out};
    cyc(1);
  endtask

  task automatic bar();
    barrier_in = 1'h1;
    cyc(1);
    barrier_in = 1'h0;
  endtask
  // --------------------
  // Scenarios
  // --------------------
  task automatic t_write_through();
    {n0, c0} = {mem_n, c_n};
    issue(`CPAP_KIND_STORE, 32'h100, 64'h11, 8'h01, 5'h14, 2'h2);
    `CHK(c_n - c0, 1)
    `CHK(c_fl, 2'h0)
    `CHK({cache_addr_out, cache_wdata_out, cache_be_out}, {32'h100, 64'h11, 8'h01})
    issue(`CPAP_KIND_STORE, 32'h100, 64'h2200, 8'h02, 5'h14, 2'h3);
    `CHK(c_fl, 2'h1)
    `CHK(mem_n - n0, 0)
    bar();
    cyc(12);
    `CHK(mem_n - n0, 1)
    `CHK({m_fl[11], m_fl[7:0], m_addr, m_data[15:0]}, {1'h1, 8'h03, 32'h100, 16'h2211})
    issue(`CPAP_KIND_STORE, 32'h100, 64'h33, 8'h01, 5'h14, 2'h0);
    bar();
    issue(`CPAP_KIND_STORE, 32'h100, 64'h4400, 8'h02, 5'h14, 2'h0);
    cyc(20);
    `CHK({mem_n - n0, m_fl[7:0]}, {32'h3, 8'h02})
    $display("test write_through done");
  endtask

  task automatic t_inhibited_load();
    for (k = 0; k < 4; k++) begin
      {n0, c0} = {mem_n, c_n};
      issue(k[1] ? `CPAP_KIND_IFETCH : `CPAP_KIND_LOAD, 32'h200, 64'h0, 8'hff, {3'h3, k[0], 1'h0}, 2'h2);
      `CHK({mem_n - n0, c_n - c0}, {32'h1, 32'h0})
      `CHK({m_fl[11], m_fl[9], r_data}, {2'h0, 32'h200, ~32'h200})
      if (k == 1) `CHK(m_fl[10], 1'h0)
    end
    $display("test inhibited_load done");
  endtask

  task automatic t_inhibited_store();
    {slow, c0} = {1'h1, c_n};
    for (k = 0; k < 3; k++) begin
      n0 = mem_n;
      issue(`CPAP_KIND_STORE, 32'h300, 64'h11, 8'h01, k ? 5'h0c : 5'h0e, 2'h2);
      issue(`CPAP_KIND_STORE, 32'h300, 64'h2200, k == 1 ? 8'h02 : 8'h01, k ? 5'h0c : 5'h0e, 2'h2);
      cyc(20);
      `CHK(mem_n - n0, k == 1 ? 1 : 2)
      if (k == 1) `CHK(m_fl[7:0], 8'h03)
    end
    `CHK(c_n - c0, 0)
    slow = 1'h0;
    $display("test inhibited_store done");
  endtask

  task automatic t_refused();
    {n0, c0} = {mem_n, c_n};
    issue(`CPAP_KIND_STORE, 32'h400, 64'h55, 8'hff, 5'h18, 2'h2);
    `CHK({r_err, r_retry}, 2'h2)
    issue(`CPAP_KIND_LOAD, 32'h400, 64'h0, 8'hff, 5'h07, 2'h0);
    `CHK({r_err, r_retry, mem_n - n0, c_n - c0}, {2'h1, 32'h0, 32'h0})
    issue(`CPAP_KIND_LOAD, 32'h400, 64'h0, 8'hff, 5'h07, 2'h2);
    `CHK({r_err, r_retry, r_data}, {2'h0, cache_rdata_in})
    issue(`CPAP_KIND_LOAD, 32'h480, 64'h0, 8'hff, 5'h05, 2'h0);
    `CHK({r_retry, r_data}, {1'h0, 32'h480, ~32'h480})
    $display("test refused done");
  endtask

  task automatic t_write_back();
    n0 = mem_n;
    issue(`CPAP_KIND_STORE, 32'h500, 64'h77, 8'h01, 5'h04, 2'h2);
    `CHK({c_fl, mem_n - n0}, {2'h2, 32'h0})
    issue(`CPAP_KIND_LOAD, 32'h520, 64'h0, 8'hff, 5'h00, 2'h0);
    `CHK(m_fl[9:8], 2'h2)
    issue(`CPAP_KIND_LOAD, 32'h540, 64'h0, 8'hff, 5'h04, 2'h0);
    `CHK(m_fl[9:8], 2'h3)
    issue(`CPAP_KIND_STORE, 32'h560, 64'h88, 8'h01, 5'h04, 2'h0);
    `CHK({m_fl[11:8], mem_l2_out}, {4'hb, 1'h0})
    $display("test write_back done");
  endtask

  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    cyc(4);
    reset_n_in = 1'h1;
    cyc(2);
    t_write_through();
    t_inhibited_load();
    t_inhibited_store();
    t_refused();
    t_write_back();
    report_and_stop();
  end

  initial begin
    #50000;
    err_total++;
    $display("unexpected %0t: run did not finish", $time);
    report_and_stop();
  end
endmodule // tb_top
